/* File: design/crcec_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "crcec_params.svh"

module crcec_top #(
  parameter int FIFO_DEPTH = `CRCEC_FIFO_DEPTH
) (
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire logic [7:0]         sfr_addr,
  input  wire logic               sfr_wr,
  input  wire logic               sfr_rd,
  input  wire crcec_pkg::crcec_byte_t sfr_wdata,
  output var  crcec_pkg::crcec_byte_t sfr_rdata,
  output var  logic               in_ready,
  output var  logic               busy
);
  import crcec_pkg::*;

  crcec_fifo_if #(.WIDTH(`CRCEC_FIFO_WIDTH)) buf_if ();

  // Input bytes wait here so that a burst of writes never stalls the port.
  crcec_fifo #(
    .WIDTH (`CRCEC_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .port    (buf_if.fifo)
  );

  crcec_ctrl_s   ctrl;
  crcec_result_t result;
  crcec_ctrl_s   next_ctrl;
  crcec_result_t next_result;
  crcec_byte_t   next_sfr_rdata;
  logic          next_in_ready;
  logic          next_busy;

  logic          wr_control;
  logic          wr_input;
  logic          wr_data_port;
  logic          rd_control;
  logic          rd_data_port;
  logic          do_init;
  logic          engine_stall;
  logic          engine_step;
  logic [1:0]    byte_index;
  crcec_byte_t   selected_byte;
  // Fold network: entry k holds the remainder after k input bits.
  logic [31:0]   stage32 [0:8];
  logic [15:0]   stage16 [0:8];
  crcec_result_t folded;

  // Register port decode; each strobe is qualified by its own address.
  always_comb begin
    wr_control   = 1'b0;
    wr_input     = 1'b0;
    wr_data_port = 1'b0;
    rd_control   = 1'b0;
    rd_data_port = 1'b0;
    case (sfr_addr)
      `CRCEC_ADDR_CONTROL: begin
        wr_control = sfr_wr;
        rd_control = sfr_rd;
      end
      `CRCEC_ADDR_INPUT_BYTE: begin
        wr_input = sfr_wr;
      end
      `CRCEC_ADDR_RESULT_DATA: begin
        wr_data_port = sfr_wr;
        rd_data_port = sfr_rd;
      end
      default: begin
        // Unmapped addresses: writes are ignored and reads return zero.
      end
    endcase
  end

  // Init is a trigger: the bit itself is never stored.
  assign do_init      = wr_control && sfr_wdata[`CRCEC_BIT_RESULT_INIT];

  // A software init or data-port write takes the cycle; the buffered byte waits one clock.
  assign engine_stall = do_init || wr_data_port;
  assign engine_step  = buf_if.rd_valid && !engine_stall;

  // Bytes queue in order; a write while the buffer is full is dropped.
  assign buf_if.wr_valid = wr_input;
  assign buf_if.wr_data  = sfr_wdata;
  assign buf_if.rd_ready = !engine_stall;

  // In 16-bit mode only the low pointer bit picks a byte.
  assign byte_index = (ctrl.poly_select == CRCEC_POLY_16) ?
                      {1'b0, ctrl.result_byte_pointer[0]} :
                      ctrl.result_byte_pointer;

  assign selected_byte = result[byte_index*8 +: 8];

  // One shift-and-reduce stage per input bit, most significant bit first.
  assign stage32[0] = result;
  assign stage16[0] = result[15:0];

  for (genvar g = 0; g < 8; g++) begin : g_fold
    logic in_bit;
    logic fb32;
    logic fb16;

    assign in_bit         = buf_if.rd_data[7 - g];
    assign fb32           = stage32[g][31] ^ in_bit;
    assign fb16           = stage16[g][15] ^ in_bit;
    assign stage32[g + 1] = {stage32[g][30:0], 1'h0} ^
                            (fb32 ? `CRCEC_POLY32 : `CRCEC_INIT_ZERO);
    assign stage16[g + 1] = {stage16[g][14:0], 1'h0} ^
                            (fb16 ? `CRCEC_POLY16 : 16'h0000);
  end

  // A 16-bit fold leaves the upper half of the result untouched.
  assign folded = (ctrl.poly_select == CRCEC_POLY_16) ?
                  {result[31:16], stage16[8]} : stage32[8];

  // Control group: bits 7:5 are not stored and the init bit is a trigger only.
  always_comb begin
    next_ctrl = ctrl;
    if (wr_control) begin
      next_ctrl.poly_select         = crcec_poly_e'(sfr_wdata[`CRCEC_BIT_POLY_SELECT]);
      next_ctrl.init_value_select   = sfr_wdata[`CRCEC_BIT_INIT_VALUE];
      next_ctrl.result_byte_pointer = sfr_wdata[`CRCEC_PTR_MSB:`CRCEC_PTR_LSB];
    end else if (wr_data_port || rd_data_port) begin
      // A read and a write of the data port in one cycle advance the pointer once.
      next_ctrl.result_byte_pointer = ctrl.result_byte_pointer + 2'd1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= crcec_ctrl_s'(4'h0);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Result group: software access wins over the engine in the same cycle.
  always_comb begin
    next_result = result;
    if (do_init) begin
      next_result = sfr_wdata[`CRCEC_BIT_INIT_VALUE] ?
                    `CRCEC_INIT_ONES : `CRCEC_INIT_ZERO;
    end else if (wr_data_port) begin
      // Only the addressed byte changes; the pointer moves in the control group.
      next_result[byte_index*8 +: 8] = sfr_wdata;
    end else if (engine_step) begin
      next_result = folded;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      result <= `CRCEC_RESULT_RESET;
    end else begin
      result <= next_result;
    end
  end

  // Read group: the port shows zero in every cycle that follows no read.
  always_comb begin
    next_sfr_rdata = 8'h00;
    if (rd_control) begin
      next_sfr_rdata = {3'h0, ctrl.poly_select, 1'h0,
                        ctrl.init_value_select, ctrl.result_byte_pointer};
    end else if (rd_data_port) begin
      next_sfr_rdata = selected_byte;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= next_sfr_rdata;
    end
  end

  // Buffer view: registered, so it trails the buffer's own flag by one clock.
  always_comb begin
    next_in_ready = buf_if.wr_ready;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= next_in_ready;
    end
  end

  // Engine activity: a byte being written counts, so busy never misses a fold.
  always_comb begin
    next_busy = buf_if.rd_valid || wr_input;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
    end else begin
      busy <= next_busy;
    end
  end
endmodule : crcec_top

`default_nettype wire

/* File: design/crcec_params.svh */
`ifndef CRCEC_PARAMS_SVH
`define CRCEC_PARAMS_SVH

// Register addresses on the special-function register port.
`define CRCEC_ADDR_CONTROL     8'h91
`define CRCEC_ADDR_INPUT_BYTE  8'h93
`define CRCEC_ADDR_RESULT_DATA 8'h94

// Control register field positions.
`define CRCEC_BIT_POLY_SELECT  4
`define CRCEC_BIT_RESULT_INIT  3
`define CRCEC_BIT_INIT_VALUE   2
`define CRCEC_PTR_MSB          1
`define CRCEC_PTR_LSB          0

// Reset values.
`define CRCEC_CONTROL_RESET    8'h00
`define CRCEC_RESULT_RESET     32'h00000000

// Generator polynomials and start values.
`define CRCEC_POLY32           32'h04c11db7
`define CRCEC_POLY16           16'h1021
`define CRCEC_INIT_ZERO        32'h00000000
`define CRCEC_INIT_ONES        32'hffffffff

// Buffer shape.
`define CRCEC_FIFO_DEPTH       32
`define CRCEC_FIFO_WIDTH       8

`endif

/* File: design/crcec_pkg.sv */
package crcec_pkg;

  typedef logic [7:0] crcec_byte_t;
  typedef logic [31:0] crcec_result_t;

  typedef enum logic [0:0] {
    CRCEC_POLY_32 = 1'b0,
    CRCEC_POLY_16 = 1'b1
  } crcec_poly_e;

  typedef struct packed {
    crcec_poly_e poly_select;
    logic        init_value_select;
    logic [1:0]  result_byte_pointer;
  } crcec_ctrl_s;

endpackage : crcec_pkg

/* File: design/crcec_fifo_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface crcec_fifo_if #(
  parameter int WIDTH = 8
);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;

  modport fifo (
    input  wr_valid,
    output wr_ready,
    input  wr_data,
    output rd_valid,
    input  rd_ready,
    output rd_data
  );

  modport user (
    output wr_valid,
    input  wr_ready,
    output wr_data,
    input  rd_valid,
    output rd_ready,
    input  rd_data
  );
endinterface : crcec_fifo_if

`default_nettype wire

/* File: design/crcec_fifo.sv */
`timescale 1ns/10ps
`default_nettype none

module crcec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic  ref_clk,
  input  wire logic  rstn,
  crcec_fifo_if.fifo port
);
  import crcec_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             not_full;
  logic             not_empty;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push          = port.wr_valid & not_full;
  assign pop           = port.rd_ready & not_empty;
  assign port.wr_ready = not_full;
  assign port.rd_valid = not_empty;
  assign port.rd_data  = mem[rd_ptr];

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      not_full  <= 1'b1;
      not_empty <= 1'b0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      not_full  <= (next_count != (AW+1)'(DEPTH));
      not_empty <= (next_count != '0);
    end
  end

  // Storage has no reset so it maps onto plain memory.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= port.wr_data;
    end
  end
endmodule : crcec_fifo

`default_nettype wire

/* File: sim/crcec_properties.sv */
`timescale 1ns/10ps
`default_nettype none
`include "crcec_params.svh"

module crcec_properties (
  input wire logic                   ref_clk,
  input wire logic                   rstn,
  input wire logic [7:0]             sfr_addr,
  input wire logic                   sfr_wr,
  input wire logic                   sfr_rd,
  input wire crcec_pkg::crcec_byte_t sfr_wdata,
  input wire crcec_pkg::crcec_byte_t sfr_rdata,
  input wire logic                   in_ready,
  input wire logic                   busy
);
  import crcec_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire logic feed = sfr_wr && sfr_addr == `CRCEC_ADDR_INPUT_BYTE;
  wire logic crd = sfr_rd && sfr_addr == `CRCEC_ADDR_CONTROL;
  wire logic drd = sfr_rd && sfr_addr == `CRCEC_ADDR_RESULT_DATA;

  AST_IDLE_ZERO: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data not zero when idle");
  AST_CTL_UPPER: assert property (crd |=> sfr_rdata[7:5] == 3'h0)
    else $error("control upper bits not zero");
  AST_INIT_SELF: assert property (crd |=> !sfr_rdata[3])
    else $error("init bit reads back set");
  AST_NOREG_ZERO: assert property (sfr_rd && !crd && !drd |=> sfr_rdata == 8'h00)
    else $error("non-readable address returned data");
  AST_FEED_BUSY: assert property (feed && in_ready |-> ##[1:2] busy)
    else $error("accepted byte did not raise busy");
  AST_BUSY_BOUND: assert property (busy |-> ##[1:60] !busy)
    else $error("busy stuck high");
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(feed) || $past(feed, 2))
    else $error("busy rose without input byte");
  AST_READY_CAUSE: assert property ($fell(in_ready) |-> $past(feed) || $past(feed, 2))
    else $error("ready fell without input byte");

  CVR_FEED: cover property (feed && in_ready);
  CVR_FULL: cover property ($fell(in_ready));
  CVR_READ: cover property (drd);
endmodule : crcec_properties

bind crcec_top crcec_properties u_props (.ref_clk(ref_clk), .rstn(rstn), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .in_ready(in_ready), .busy(busy));

`default_nettype wire

/* File: sim/tb_crc_engine_control.sv */
`timescale 1ns/10ps
`default_nettype none
`include "crcec_params.svh"

module tb_crc_engine_control;
  import crcec_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  crcec_byte_t sfr_wdata = 8'h00;
  crcec_byte_t sfr_rdata;
  logic        in_ready;
  logic        busy;
  int          n_errors = 0;
  int          checks_done = 0;

  always #2.5 ref_clk = ~ref_clk;

  crcec_top #(.FIFO_DEPTH(4)) dut (.ref_clk(ref_clk), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .in_ready(in_ready), .busy(busy));

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string w, input logic [7:0] s, input logic [7:0] x);
    checks_done++;
    if (s !== x) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, x, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input crcec_byte_t d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input crcec_byte_t x, input string w);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    chk(w, sfr_rdata, x);
  endtask : rdc

  task automatic idle();
    int i;
    i = 0;
    repeat (2) @(negedge ref_clk);
    while (busy !== 1'b0) begin
      @(negedge ref_clk);
      i++;
      if (i > 200) begin
        n_errors++;
        conclude();
      end
    end
  endtask : idle

  // Bit-serial reference, most significant bit first, no reflection.
  function automatic logic [31:0] fold(input logic [31:0] r, input crcec_byte_t b,
                                       input logic s);
    logic [31:0] t;
    t = r;
    for (int k = 7; k >= 0; k--) begin
      if (s) t[15:0] = {t[14:0], 1'b0} ^ ((t[15] ^ b[k]) ? 16'h1021 : 16'h0000);
      else t = {t[30:0], 1'b0} ^ ((t[31] ^ b[k]) ? 32'h04c11db7 : 32'h00000000);
    end
    return t;
  endfunction : fold

  task automatic t_ctrl();
    rdc(8'h91, 8'h00, "ctrl reset");
    wr(8'h91, 8'hff);
    rdc(8'h91, 8'h17, "ctrl bits");
    wr(8'h55, 8'haa);
    rdc(8'h91, 8'h17, "unmapped write");
    rdc(8'h55, 8'h00, "unmapped read");
    rdc(8'h93, 8'h00, "input read");
  endtask : t_ctrl

  task automatic t_ptr();
    logic [31:0] e;
    e = 32'h00a50000;
    wr(8'h91, 8'h0c);
    for (int k = 0; k < 4; k++) rdc(8'h94, 8'hff, "init ones");
    rdc(8'h91, 8'h04, "ptr wrap");
    wr(8'h91, 8'h0a);
    wr(8'h94, 8'ha5);
    rdc(8'h91, 8'h03, "ptr after write");
    wr(8'h91, 8'h00);
    for (int k = 0; k < 4; k++) rdc(8'h94, e[8*k+:8], "byte map");
  endtask : t_ptr

  task automatic t_crc(input logic s);
    logic [31:0] e;
    e = 32'hffffffff;
    wr(8'h91, s ? 8'h1c : 8'h0c);
    for (int k = 0; k < 9; k++) begin
      wr(8'h93, 8'h31 + 8'(k));
      chk("busy", {7'h00, busy}, 8'h01);
      idle();
      e = fold(e, 8'h31 + 8'(k), s);
    end
    for (int k = 0; k < 8; k++) rdc(8'h94, e[8*(s ? k%2 : k%4)+:8], "crc");
  endtask : t_crc

  task automatic t_burst();
    logic        low;
    logic [31:0] e;
    low = 1'b0;
    e = 32'hffffffff;
    wr(8'h91, 8'h0c);
    @(negedge ref_clk);
    sfr_addr = 8'h93;
    sfr_wr = 1'b1;
    for (int k = 0; k < 10; k++) begin
      sfr_wdata = 8'(k * 37);
      e = fold(e, 8'(k * 37), 1'b0);
      @(negedge ref_clk);
      low = low | !in_ready;
    end
    sfr_wr = 1'b0;
    idle();
    chk("ready again", {7'h00, in_ready}, 8'h01);
    chk("no drop", {7'h00, low}, 8'h00);
    for (int k = 0; k < 4; k++) rdc(8'h94, e[8*k+:8], "burst crc");
  endtask : t_burst

  task automatic t_reset();
    wr(8'h91, 8'h1f);
    @(negedge ref_clk);
    rstn = 1'b0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    chk("ready in reset", {7'h00, in_ready}, 8'h00);
    rdc(8'h91, 8'h00, "ctrl after reset");
    chk("ready after reset", {7'h00, in_ready}, 8'h01);
    for (int k = 0; k < 4; k++) rdc(8'h94, 8'h00, "result after reset");
  endtask : t_reset

  initial begin
    repeat (8) @(negedge ref_clk);
    rstn = 1'b1;
    t_ctrl();
    t_ptr();
    t_crc(1'b0);
    t_crc(1'b1);
    t_burst();
    t_reset();
    conclude();
  end
endmodule : tb_crc_engine_control

`default_nettype wire
